// *** rtl/ssse_pkg.sv ***
package ssse_pkg;

  // ****************************************************************
  // Widths and bit positions
  // ****************************************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PTR_W    = 16;
  localparam int unsigned PAGE_W   = 8;
  localparam int unsigned ADDR_W   = PAGE_W + PTR_W;
  localparam int unsigned BIT_SIGN = 7;
  localparam int unsigned BIT_LOW  = 0;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_PREFIX  = 8'hce;
  localparam logic [7:0] OPC_ASL_A   = 8'h80;
  localparam logic [7:0] OPC_ASL_B   = 8'h81;
  localparam logic [7:0] OPC_ASL_ABS = 8'h82;
  localparam logic [7:0] OPC_ASL_PTR = 8'h83;
  localparam logic [7:0] OPC_LSL_A   = 8'h84;
  localparam logic [7:0] OPC_LSL_B   = 8'h85;
  localparam logic [7:0] OPC_LSL_ABS = 8'h86;
  localparam logic [7:0] OPC_LSL_PTR = 8'h87;
  localparam logic [7:0] OPC_ASR_A   = 8'h88;
  localparam logic [7:0] OPC_ASR_B   = 8'h89;
  localparam logic [7:0] OPC_LSR_A   = 8'h8c;
  localparam logic [7:0] OPC_LSR_B   = 8'h8d;
  localparam logic [7:0] OPC_LSR_ABS = 8'h8e;
  localparam logic [7:0] OPC_LSR_PTR = 8'h8f;
  localparam logic [7:0] OPC_SLEEP   = 8'hae;
  localparam logic [7:0] OPC_SUB_A   = 8'h10;
  localparam logic [7:0] OPC_SUB_B   = 8'h11;
  // Default codes for the arithmetic right shift on memory
  localparam logic [7:0] OPC_ASR_ABS_DEF = 8'h8a;
  localparam logic [7:0] OPC_ASR_PTR_DEF = 8'h8b;

  // ****************************************************************
  // Cycle counts and sequencer points
  // ****************************************************************
  localparam logic [2:0] CYC_SUB     = 3'h2;
  localparam logic [2:0] CYC_REG     = 3'h3;
  localparam logic [2:0] CYC_SLEEP   = 3'h3;
  localparam logic [2:0] CYC_PTR     = 3'h4;
  localparam logic [2:0] CYC_ABS     = 3'h5;
  localparam logic [2:0] CNT_ONE     = 3'h1;
  localparam logic [2:0] CNT_RD_ABS  = 3'h4;
  localparam logic [2:0] CNT_CAPTURE = 3'h2;
  localparam logic [2:0] CNT_LAST    = 3'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [23:0] RST_ADDR = 24'h000000;
  localparam logic [2:0]  RST_CNT  = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ASL  = 3'h1,
    ALU_LSL  = 3'h2,
    ALU_ASR  = 3'h3,
    ALU_LSR  = 3'h4,
    ALU_SUB  = 3'h5
  } ssse_aluop_t;

  typedef enum logic [1:0] {
    MODE_REG   = 2'h0,
    MODE_ABS   = 2'h1,
    MODE_PTR   = 2'h2,
    MODE_SLEEP = 2'h3
  } ssse_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_ASLEEP = 3'b100
  } ssse_state_t;

  typedef struct packed {
    logic n;
    logic v;
    logic c;
    logic z;
  } ssse_flags_t;

  localparam ssse_flags_t RST_FLAGS = 4'h0;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] low_address_byte;
  } ssse_ibytes_t;

  typedef struct packed {
    ssse_aluop_t op;
    ssse_mode_t  mode;
    logic        sel_b;
    logic [2:0]  ncyc;
    logic        legal;
  } ssse_dec_t;

  typedef struct packed {
    logic [7:0]  res;
    ssse_flags_t flags;
  } ssse_alu_res_t;

endpackage

// *** rtl/ssse_alu.sv ***
module ssse_alu
  import ssse_pkg::*;
(
  // Operation select
  input  wire ssse_pkg::ssse_aluop_t   op,
  // Operands and current flags
  input  wire logic [7:0]              operand,
  input  wire logic [7:0]              a_val,
  input  wire ssse_pkg::ssse_flags_t   flags_in,
  // Result
  output      ssse_pkg::ssse_alu_res_t out
);

  logic [8:0] diff;

  always_comb begin
    out = {operand, flags_in};
    diff = {1'b0, a_val} - {1'b0, operand};
    case (op)
      ALU_ASL: begin
        out.res = {operand[BIT_SIGN-1:0], 1'b0};
        out.flags.c = operand[BIT_SIGN];
        out.flags.v = operand[BIT_SIGN] ^ operand[BIT_SIGN-1];
        out.flags.n = out.res[BIT_SIGN];
      end
      ALU_LSL: begin
        out.res = {operand[BIT_SIGN-1:0], 1'b0};
        out.flags.c = operand[BIT_SIGN];
        out.flags.n = out.res[BIT_SIGN];
      end
      ALU_ASR: begin
        out.res = {operand[BIT_SIGN], operand[BIT_SIGN:1]};
        out.flags.c = operand[BIT_LOW];
        out.flags.v = 1'b0;
        out.flags.n = out.res[BIT_SIGN];
      end
      ALU_LSR: begin
        out.res = {1'b0, operand[BIT_SIGN:1]};
        out.flags.c = operand[BIT_LOW];
        out.flags.n = 1'b0;
      end
      ALU_SUB: begin
        out.res = diff[DATA_W-1:0];
        out.flags.c = diff[DATA_W];
        out.flags.v = (a_val[BIT_SIGN] ^ operand[BIT_SIGN])
                    & (a_val[BIT_SIGN] ^ diff[BIT_SIGN]);
        out.flags.n = diff[BIT_SIGN];
      end
      default: begin
        out = {operand, flags_in};
      end
    endcase
    if (op != ALU_NONE) begin
      out.flags.z = (out.res == RST_DATA);
    end
  end

endmodule

// *** rtl/ssse_top.sv ***
// Summary of operation
// - Left shift: top bit to carry, zero in
// - Arithmetic left matches logical, also sets overflow
// - Logical left keeps overflow, updates N C Z
// - Arithmetic right: low bit to carry, sign kept
// - Arithmetic right clears overflow, updates N C Z
// - Logical right: zero in top, N cleared
// - Absolute form: base page high, operand byte low
// - Extended models: data page supplies page bits
// - Pointer forms read, shift, write same address
// - Arithmetic left absolute: CE 82 byte, 5 cycles
// - Arithmetic left pointer: CE 83, 4 cycles
// - Logical left register: CE 84/85, 3 cycles
// - Logical left absolute: CE 86 byte, 5 cycles
// - Logical left pointer: CE 87, 4 cycles
// - Arithmetic right register: CE 88/89, 3 cycles
// - Arithmetic right memory: 5 absolute, 4 pointer
// - Logical right register: CE 8C/8D, 3 cycles
// - Logical right memory: CE 8E/8F, 5/4 cycles
// - Sleep: CE AE, 3 cycles, enters sleep
// - Asleep, core, peripherals and oscillator stop
// - Subtract into A: 10H/11H, 2 cycles, NVCZ
module ssse_top
  import ssse_pkg::*;
#(
  parameter logic [7:0] OPC_ASR_ABS = ssse_pkg::OPC_ASR_ABS_DEF,
  parameter logic [7:0] OPC_ASR_PTR = ssse_pkg::OPC_ASR_PTR_DEF
) (
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RST_N,
  // Instruction issue
  input  wire logic                   ISSUE,
  input  wire ssse_pkg::ssse_ibytes_t OP_BYTES,
  // Register preset from the core
  input  wire logic                   LOAD,
  input  wire logic [7:0]             LOAD_A,
  input  wire logic [7:0]             LOAD_B,
  input  wire ssse_pkg::ssse_flags_t  LOAD_FLAGS,
  // Page and pointer context
  input  wire logic [7:0]             BASE_PAGE_REG,
  input  wire logic [7:0]             DATA_PAGE_REG,
  input  wire logic [15:0]            POINTER_PAIR_REG,
  input  wire logic                   EXTENDED_MEMORY_MODELS,
  // Data memory
  input  wire logic [7:0]             MEM_RDATA,
  output      logic                   MEM_RD,
  output      logic                   MEM_WR,
  output      logic [23:0]            MEM_ADDR,
  output      logic [7:0]             MEM_WDATA,
  // Wake-up interrupt from outside the chip
  input  wire logic                   WAKE_IRQ,
  // Core state and status
  output      logic [7:0]             REG_A,
  output      logic [7:0]             REG_B,
  output      ssse_pkg::ssse_flags_t  STATUS_FLAGS_REG,
  output      logic                   BUSY,
  output      logic                   DONE,
  output      logic                   ILLEGAL,
  output      logic                   SLEEP_STOP
);
  import ssse_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ssse_state_t   state_r;
  ssse_state_t   state_nxt;
  logic [2:0]    cnt_r;
  ssse_aluop_t   op_r;
  ssse_mode_t    mode_r;
  logic          sel_b_r;
  logic [7:0]    opnd_r;
  logic [7:0]    reg_a_r;
  logic [7:0]    reg_b_r;
  ssse_flags_t   flags_r;
  logic [23:0]   addr_r;
  logic [7:0]    wdata_r;
  logic          mem_rd_r;
  logic          mem_wr_r;
  logic          busy_r;
  logic          done_r;
  logic          illegal_r;
  logic          sleep_r;
  logic          wake_meta_r;
  logic          wake_sync_r;
  ssse_dec_t     dec;
  logic          take;
  logic          exec;
  logic          capture;
  logic          last;
  logic [7:0]    page;
  logic [7:0]    alu_operand;
  ssse_alu_res_t alu_out;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  function automatic ssse_dec_t decode(input ssse_ibytes_t ib);
    ssse_dec_t d;
    d = '0;
    if (ib.first == OPC_PREFIX) begin
      d.legal = 1'b1;
      d.sel_b = (ib.second == OPC_ASL_B) || (ib.second == OPC_LSL_B)
             || (ib.second == OPC_ASR_B) || (ib.second == OPC_LSR_B);
      if (ib.second == OPC_ASL_A || ib.second == OPC_ASL_B) begin
        d.op = ALU_ASL;
        d.mode = MODE_REG;
        d.ncyc = CYC_REG;
      end else if (ib.second == OPC_ASL_ABS) begin
        d.op = ALU_ASL;
        d.mode = MODE_ABS;
        d.ncyc = CYC_ABS;
      end else if (ib.second == OPC_ASL_PTR) begin
        d.op = ALU_ASL;
        d.mode = MODE_PTR;
        d.ncyc = CYC_PTR;
      end else if (ib.second == OPC_LSL_A || ib.second == OPC_LSL_B) begin
        d.op = ALU_LSL;
        d.mode = MODE_REG;
        d.ncyc = CYC_REG;
      end else if (ib.second == OPC_LSL_ABS) begin
        d.op = ALU_LSL;
        d.mode = MODE_ABS;
        d.ncyc = CYC_ABS;
      end else if (ib.second == OPC_LSL_PTR) begin
        d.op = ALU_LSL;
        d.mode = MODE_PTR;
        d.ncyc = CYC_PTR;
      end else if (ib.second == OPC_ASR_A || ib.second == OPC_ASR_B) begin
        d.op = ALU_ASR;
        d.mode = MODE_REG;
        d.ncyc = CYC_REG;
      end else if (ib.second == OPC_ASR_ABS) begin
        d.op = ALU_ASR;
        d.mode = MODE_ABS;
        d.ncyc = CYC_ABS;
      end else if (ib.second == OPC_ASR_PTR) begin
        d.op = ALU_ASR;
        d.mode = MODE_PTR;
        d.ncyc = CYC_PTR;
      end else if (ib.second == OPC_LSR_A || ib.second == OPC_LSR_B) begin
        d.op = ALU_LSR;
        d.mode = MODE_REG;
        d.ncyc = CYC_REG;
      end else if (ib.second == OPC_LSR_ABS) begin
        d.op = ALU_LSR;
        d.mode = MODE_ABS;
        d.ncyc = CYC_ABS;
      end else if (ib.second == OPC_LSR_PTR) begin
        d.op = ALU_LSR;
        d.mode = MODE_PTR;
        d.ncyc = CYC_PTR;
      end else if (ib.second == OPC_SLEEP) begin
        d.op = ALU_NONE;
        d.mode = MODE_SLEEP;
        d.ncyc = CYC_SLEEP;
      end else begin
        d.legal = 1'b0;
      end
    end else if (ib.first == OPC_SUB_A || ib.first == OPC_SUB_B) begin
      d.legal = 1'b1;
      d.op = ALU_SUB;
      d.mode = MODE_REG;
      d.sel_b = (ib.first == OPC_SUB_B);
      d.ncyc = CYC_SUB;
    end
    return d;
  endfunction

  assign dec     = decode(OP_BYTES);
  // Preset wins over issue so the latched operand is never stale
  assign take    = (state_r == ST_IDLE) && ISSUE && !LOAD && dec.legal;
  assign exec    = (state_r == ST_EXEC);
  assign capture = exec && (mode_r == MODE_ABS || mode_r == MODE_PTR)
                && (cnt_r == CNT_CAPTURE);
  assign last    = exec && (cnt_r == CNT_LAST);
  assign page    = EXTENDED_MEMORY_MODELS ? DATA_PAGE_REG : RST_DATA;
  assign alu_operand = capture ? MEM_RDATA : opnd_r;

  ssse_alu u_alu (
    .op       (op_r),
    .operand  (alu_operand),
    .a_val    (reg_a_r),
    .flags_in (flags_r),
    .out      (alu_out)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_r == CNT_LAST) begin
          state_nxt = (mode_r == MODE_SLEEP) ? ST_ASLEEP : ST_IDLE;
        end
      end
      ST_ASLEEP: begin
        if (wake_sync_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r   <= ST_IDLE;
      cnt_r     <= RST_CNT;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
      sleep_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      busy_r    <= (state_nxt == ST_EXEC);
      done_r    <= last;
      illegal_r <= (state_r == ST_IDLE) && ISSUE && !LOAD && !dec.legal;
      // Stop request for core clock, peripherals and oscillator
      sleep_r   <= (state_nxt == ST_ASLEEP);
      if (take) begin
        cnt_r <= dec.ncyc - CNT_ONE;
      end else if (exec) begin
        cnt_r <= cnt_r - CNT_ONE;
      end
    end
  end

  // ****************************************************************
  // Wake-up synchroniser
  // ****************************************************************
  // The clock this samples must keep running while asleep, or be
  // restarted by the wake source itself outside this block.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
    end else begin
      wake_meta_r <= WAKE_IRQ;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ****************************************************************
  // Latched instruction
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      op_r    <= ALU_NONE;
      mode_r  <= MODE_REG;
      sel_b_r <= 1'b0;
      opnd_r  <= RST_DATA;
    end else if (take) begin
      op_r    <= dec.op;
      mode_r  <= dec.mode;
      sel_b_r <= dec.sel_b;
      opnd_r  <= dec.sel_b ? reg_b_r : reg_a_r;
    end else if (capture) begin
      opnd_r  <= MEM_RDATA;
    end
  end

  // ****************************************************************
  // Data memory access
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r   <= RST_ADDR;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      wdata_r  <= RST_DATA;
    end else begin
      if (take && dec.mode == MODE_PTR) begin
        addr_r <= {page, POINTER_PAIR_REG};
      end else if (take && dec.mode == MODE_ABS) begin
        addr_r <= {page, BASE_PAGE_REG, OP_BYTES.low_address_byte};
      end
      // Both memory forms read in the cycle where the count is three
      mem_rd_r <= (take && dec.mode == MODE_PTR)
               || (exec && mode_r == MODE_ABS && cnt_r == CNT_RD_ABS);
      mem_wr_r <= capture;
      if (capture) begin
        wdata_r <= alu_out.res;
      end
    end
  end

  // ****************************************************************
  // Architectural registers
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_a_r <= RST_DATA;
      reg_b_r <= RST_DATA;
      flags_r <= RST_FLAGS;
    end else if (state_r == ST_IDLE && LOAD) begin
      reg_a_r <= LOAD_A;
      reg_b_r <= LOAD_B;
      flags_r <= LOAD_FLAGS;
    end else if (last && mode_r != MODE_SLEEP) begin
      flags_r <= alu_out.flags;
      if (mode_r == MODE_REG) begin
        if (op_r == ALU_SUB || !sel_b_r) begin
          reg_a_r <= alu_out.res;
        end else begin
          reg_b_r <= alu_out.res;
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign MEM_RD           = mem_rd_r;
  assign MEM_WR           = mem_wr_r;
  assign MEM_ADDR         = addr_r;
  assign MEM_WDATA        = wdata_r;
  assign REG_A            = reg_a_r;
  assign REG_B            = reg_b_r;
  assign STATUS_FLAGS_REG = flags_r;
  assign BUSY             = busy_r;
  assign DONE             = done_r;
  assign ILLEGAL          = illegal_r;
  assign SLEEP_STOP       = sleep_r;

endmodule

// *** testbench/ssse_mem_model.sv ***
module ssse_mem_model (
  // Bus from the block
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  wdata,
  // Read data back
  output      logic [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [logic [23:0]];

  initial rdata = 8'h00;

  // Read data is valid for one cycle only; the bus then toggles so a late capture shows up
  always @(posedge clk) begin
    if (rd)
      rdata <= mem.exists(addr) ? mem[addr] : 8'h00;
    else
      rdata <= ~rdata;
    if (wr)
      mem[addr] = wdata;
  end
endmodule

// *** testbench/ssse_checker_properties.sv ***
module ssse_checker (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // Page context and wake
  input wire logic [7:0]  DATA_PAGE_REG,
  input wire logic        EXTENDED_MEMORY_MODELS,
  input wire logic        WAKE_IRQ,
  // Memory side and status
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic [23:0] MEM_ADDR,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        SLEEP_STOP
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_read_pulse: assert property (MEM_RD |=> !MEM_RD)
    else $error("memory read longer than one cycle");
  a_read_to_write: assert property (MEM_RD |-> ##2 MEM_WR)
    else $error("write back not two cycles after read");
  a_addr_held: assert property (MEM_RD |=> $stable(MEM_ADDR) [*2])
    else $error("address moved between read and write");
  a_write_done: assert property (MEM_WR |=> DONE && !MEM_WR)
    else $error("completion not right after write back");
  a_page_select: assert property (MEM_RD |-> MEM_ADDR[23:16] ==
      (EXTENDED_MEMORY_MODELS ? DATA_PAGE_REG : 8'h00))
    else $error("wrong page on memory access");
  a_done_busy: assert property (DONE && !SLEEP_STOP |-> !BUSY ##1 !DONE)
    else $error("busy still high at done or done longer than one cycle");
  a_busy_bound: assert property ($rose(BUSY) |-> ##[0:4] DONE)
    else $error("operation longer than five cycles");
  a_sleep_enter: assert property ($rose(SLEEP_STOP) |-> DONE)
    else $error("sleep entered without completion");
  a_sleep_quiet: assert property (SLEEP_STOP && !DONE |-> !BUSY && !MEM_RD && !MEM_WR)
    else $error("activity while asleep");
  a_sleep_hold: assert property (SLEEP_STOP && !WAKE_IRQ && !$past(WAKE_IRQ) &&
      !$past(WAKE_IRQ, 2) |=> SLEEP_STOP)
    else $error("sleep left without wake request");
  a_wake_exit: assert property ($rose(WAKE_IRQ) && SLEEP_STOP |-> ##[1:4] !SLEEP_STOP)
    else $error("wake request did not end sleep");
endmodule

bind ssse_top ssse_checker ssse_checker_i (
  .MCLK                   (MCLK),
  .RST_N                  (RST_N),
  .DATA_PAGE_REG          (DATA_PAGE_REG),
  .EXTENDED_MEMORY_MODELS (EXTENDED_MEMORY_MODELS),
  .WAKE_IRQ               (WAKE_IRQ),
  .MEM_RD                 (MEM_RD),
  .MEM_WR                 (MEM_WR),
  .MEM_ADDR               (MEM_ADDR),
  .BUSY                   (BUSY),
  .DONE                   (DONE),
  .SLEEP_STOP             (SLEEP_STOP)
);

// *** testbench/tb_top.sv ***
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  import ssse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          mclk, rst_n, issue, load, ext_mm, wake, busy, done, illegal, sleep_stop;
  logic          rd, wr;
  ssse_ibytes_t  op_bytes;
  logic [7:0]    load_a, load_b, base_pg, data_pg, rdata, wdata, reg_a, reg_b;
  logic [15:0]   ptr;
  logic [23:0]   addr;
  ssse_flags_t   load_flags, flags;
  int            miscompares = 0;
  int            checked = 0;
  int            cycles = 0;
  int            seed = 32'hfa150d3b;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ssse_top ssse_top_i (
    .MCLK(mclk), .RST_N(rst_n), .ISSUE(issue), .OP_BYTES(op_bytes), .LOAD(load),
    .LOAD_A(load_a), .LOAD_B(load_b), .LOAD_FLAGS(load_flags), .BASE_PAGE_REG(base_pg),
    .DATA_PAGE_REG(data_pg), .POINTER_PAIR_REG(ptr), .EXTENDED_MEMORY_MODELS(ext_mm),
    .MEM_RDATA(rdata), .MEM_RD(rd), .MEM_WR(wr), .MEM_ADDR(addr), .MEM_WDATA(wdata),
    .WAKE_IRQ(wake), .REG_A(reg_a), .REG_B(reg_b), .STATUS_FLAGS_REG(flags), .BUSY(busy),
    .DONE(done), .ILLEGAL(illegal), .SLEEP_STOP(sleep_stop));

  ssse_mem_model mem_i (.clk(mclk), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata));

  // ********************
  // Expectation and driving
  // ********************
  function automatic ssse_alu_res_t expect_alu(input logic [2:0] k, input logic [7:0] x, a,
                                               input ssse_flags_t f);
    ssse_alu_res_t r;
    r.flags = f;
    case (k)
      3'h0: begin r.res = {x[6:0], 1'b0}; r.flags.v = x[7] ^ x[6]; r.flags.c = x[7]; end
      3'h1: begin r.res = {x[6:0], 1'b0}; r.flags.c = x[7]; end
      3'h2: begin r.res = {x[7], x[7:1]}; r.flags.v = 1'b0; r.flags.c = x[0]; end
      3'h3: begin r.res = {1'b0, x[7:1]}; r.flags.c = x[0]; end
      default: begin
        r.res = a - x;
        r.flags.c = a < x;
        r.flags.v = (a[7] != x[7]) && (r.res[7] != a[7]);
      end
    endcase
    r.flags.n = r.res[7];
    r.flags.z = r.res == 8'h00;
    return r;
  endfunction

  task automatic exec(input logic [7:0] f, s, l, a, b, input ssse_flags_t fl, input int nexp);
    int n;
    @(posedge mclk);
    load <= 1'b1;
    load_a <= a;
    load_b <= b;
    load_flags <= fl;
    @(posedge mclk);
    load <= 1'b0;
    op_bytes <= {f, s, l};
    issue <= 1'b1;
    @(posedge mclk);
    issue <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 10);
    `CHK(n, nexp - 1)
  endtask

  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole sequence needs about 3600 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    logic [7:0]    a, b, x, code, low, bpg, dpg;
    logic [15:0]   pp;
    logic          ext;
    logic [23:0]   ea;
    ssse_flags_t   fl;
    ssse_alu_res_t r;
    int            n;
    static logic [7:0] corner [4] = '{8'h80, 8'h01, 8'h00, 8'hff};
    {rst_n, issue, load, ext_mm, wake} = 5'h0;
    {op_bytes, load_a, load_b, base_pg, data_pg, ptr} = '0;
    load_flags = 4'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // Back to back: ISSUE held high is taken again on the edge where DONE
    // stands, but the request seen while busy must not start a third run
    @(posedge mclk);
    load <= 1'b1;
    load_a <= 8'h01;
    @(posedge mclk);
    load <= 1'b0;
    op_bytes <= {8'hce, 8'h84, 8'h00};
    issue <= 1'b1;
    repeat (6) @(posedge mclk);
    issue <= 1'b0;
    #1;
    `CHK(done, 1'b1)
    `CHK(reg_a, 8'h04)
    @(posedge mclk);
    #1;
    `CHK(busy, 1'b0)
    // Unknown code gives a single refusal pulse
    @(posedge mclk);
    op_bytes <= {8'hce, 8'hff, 8'h00};
    issue <= 1'b1;
    @(posedge mclk);
    issue <= 1'b0;
    n = 0;
    repeat (3) begin
      #1;
      n += int'(illegal === 1'b1);
      @(posedge mclk);
    end
    #1;
    `CHK(n, 1)
    `CHK(busy, 1'b0)
    // Sleep, ignore work while asleep, then wake from outside
    exec(8'hce, 8'hae, 8'h00, 8'h5a, 8'h00, 4'h0, 3);
    `CHK(sleep_stop, 1'b1)
    @(posedge mclk);
    op_bytes <= {8'hce, 8'h84, 8'h00};
    issue <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK(busy, 1'b0)
    `CHK(reg_a, 8'h5a)
    @(posedge mclk);
    issue <= 1'b0;
    wake <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (sleep_stop !== 1'b0 && n < 8);
    `CHK(n, 3)
    @(posedge mclk);
    wake <= 1'b0;
    // Every shift code and both subtracts, corners first, then random
    for (int it = 0; it < 30; it++) begin
      for (int j = 0; j < 18; j++) begin
        code = (j < 16) ? 8'(8'h80 + j) : 8'(j);
        {a, b, x, low} = $random(seed);
        {bpg, dpg, pp} = $random(seed);
        {fl, ext} = 5'($random(seed));
        if (it < 4) begin
          a = corner[it];
          b = corner[it];
          x = corner[it];
        end
        @(posedge mclk);
        base_pg <= bpg;
        data_pg <= dpg;
        ptr <= pp;
        ext_mm <= ext;
        ea = code[0] ? {ext ? dpg : 8'h00, pp} : {ext ? dpg : 8'h00, bpg, low};
        mem_i.mem[ea] = x;
        r = expect_alu((j < 16) ? code[3:2] : 3'h4,
                       (j >= 16 || !code[1]) ? (code[0] ? b : a) : x, a, fl);
        exec((j < 16) ? 8'hce : code, code, low, a, b, fl,
             (j >= 16) ? 2 : !code[1] ? 3 : code[0] ? 4 : 5);
        if (j < 16 && code[1]) begin
          `CHK(addr, ea)
          `CHK(mem_i.mem[ea], r.res)
          `CHK(reg_a, a)
        end else if (j >= 16 || !code[0]) begin
          `CHK(reg_a, r.res)
        end else begin
          `CHK(reg_b, r.res)
        end
        `CHK(flags, r.flags)
      end
    end
    complete_run();
  end
endmodule
